// >>> rtl/cmp_compositor.sv
// cmp_compositor: per-pixel layer compositing for the panel and CRT pipes
// Behaviour
// - seven layers, fixed numbers, secondary cursor topmost
// - 64x64 2-bpp cursors, 00 transparent, three colours
// - secondary cursor only on CRT pipe
// - primary cursor only on panel pipe
// - secondary graphics: 8-bpp LUT, 565, 888
// - primary graphics: scrolling, 8/16/32-bit pixels
// - primary colour key match reveals video pixel
// - video overlays graphics, 565 or YUV 4:2:2
// - video alpha: 4:4, idx8, ARGB4444, 565
// - video alpha transparency match value in idx8 and 565 modes only
// - 565 video alpha uses one planar alpha
// - alpha layer over graphics plus video
// - blend a*c + (1-a)*under, 16 steps
// - 565 packs red 5, green 6, blue 5
// - 888 in 32 bits, top byte ignored except by the colour key compare
// - 8-bit index through LUT to 24 bits
// - active resolutions up to 1920 by 1440
// - two pipes run independently, any combination
// - video and alpha planes on panel only
`timescale 1ns/100ps
module cmp_compositor import cmp_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// control
	input wire logic [7:1] layer_en,
	input wire logic pnl_en,
	input wire logic crt_en,
	input wire logic dual_en,
	input wire cmp_pnl_cfg_t pnl_cfg,
	input wire cmp_crt_cfg_t crt_cfg,
	// lookup table write port
	input wire logic lut_we,
	input wire logic [7:0] lut_addr,
	input wire logic [23:0] lut_data,
	// pixel streams from the fetch and scaler side
	input wire cmp_pnl_in_t pnl_in,
	input wire cmp_crt_in_t crt_in,
	// composited pixels and status
	output logic [23:0] pnl_pix,
	output logic pnl_vld,
	output logic [23:0] crt_pix,
	output logic crt_vld,
	output logic bw_warn
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] exp565(input logic [15:0] p);
		return {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
	endfunction : exp565

	function automatic logic [23:0] exp4(input logic [11:0] p);
		return {p[11:8], p[11:8], p[7:4], p[7:4], p[3:0], p[3:0]};
	endfunction : exp4

	function automatic logic [23:0] gfx_dec(input cmp_gfmt_t f, input logic [31:0] p,
		input logic [23:0] lutv);
		case (f)
			GF_IDX8: return lutv;
			GF_RGB565: return exp565(p[15:0]);
			GF_RGB888: return p[23:0];
			default: return lutv;
		endcase
	endfunction : gfx_dec

	function automatic logic key_hit(input cmp_gfmt_t f, input logic [31:0] p,
		input logic [31:0] k);
		case (f)
			GF_IDX8: return p[7:0] == k[7:0];
			GF_RGB565: return p[15:0] == k[15:0];
			default: return p == k;
		endcase
	endfunction : key_hit

	// a = 15 gives the layer colour, a = 0 leaves the pixel beneath
	function automatic logic [23:0] blend(input logic [3:0] a, input logic [23:0] top,
		input logic [23:0] under);
		logic [11:0] s;
		logic [21:0] m;
		logic [23:0] r;
		r = PIX_RESET;
		for (int i = 0; i < 3; i++) begin
			s = a * top[8*i+:8] + (ALPHA_OPAQUE - a) * under[8*i+:8];
			m = 22'(s) * DIV15_MUL + DIV15_RND;
			r[8*i+:8] = m[19:12];
		end
		return r;
	endfunction : blend

	function automatic logic [7:0] idx_of(input cmp_afmt_t f, input logic [15:0] p);
		return (f == AF_A44) ? {4'h0, p[3:0]} : p[7:0];
	endfunction : idx_of

	// shared by the video alpha and alpha layers; plane is the 565 alpha
	function automatic logic [23:0] ovl(input cmp_afmt_t f, input logic [15:0] p,
		input logic [15:0] k, input logic [3:0] plane, input logic [23:0] lutv,
		input logic [23:0] under);
		case (f)
			AF_A44: return blend(p[7:4], lutv, under);
			AF_IDX8: return (p[7:0] == k[7:0]) ? under : lutv;
			AF_ARGB: return blend(p[15:12], exp4(p[11:0]), under);
			AF_RGB565: return (p == k) ? under : blend(plane, exp565(p), under);
		endcase
	endfunction : ovl

	function automatic logic cur_hit(input cmp_cur_cfg_t c, input logic [CW-1:0] x,
		input logic [CW-1:0] y);
		logic [CW-1:0] dx;
		logic [CW-1:0] dy;
		dx = x - c.x;
		dy = y - c.y;
		return x >= c.x && y >= c.y && dx < CUR_SIZE && dy < CUR_SIZE;
	endfunction : cur_hit

	function automatic logic [23:0] cur_pix(input cmp_cur_cfg_t c, input logic [1:0] code,
		input logic [23:0] under);
		return (code == CUR_TRANSP) ? under : c.col[code - 2'h1];
	endfunction : cur_pix

	function automatic logic [7:0] clip(input int v);
		return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
	endfunction : clip

	function automatic logic [23:0] yuv2rgb(input logic [7:0] y, input logic [7:0] u,
		input logic [7:0] v);
		int d;
		int e;
		d = int'(u) - YUV_OFS;
		e = int'(v) - YUV_OFS;
		return {clip(int'(y) + ((K_RV * e) >>> 8)),
			clip(int'(y) - ((K_GU * d + K_GV * e) >>> 8)),
			clip(int'(y) + ((K_BU * d) >>> 8))};
	endfunction : yuv2rgb

	////////////////////////////////////////////////////////////////////////
	// lookup table, shared by every indexed layer of both pipes; no reset,
	// software loads it before enabling indexed modes
	logic [23:0] lut [256];
	logic [23:0] next_lut [256];

	always_comb begin
		next_lut = lut;
		if (lut_we) begin
			next_lut[lut_addr] = lut_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		lut <= next_lut;
	end

	////////////////////////////////////////////////////////////////////////
	// panel pipe: layers 1 to 5 only
	logic [7:0] u_hold;
	logic [7:0] v_hold;
	logic [7:0] next_u;
	logic [7:0] next_v;
	logic [23:0] next_pnl_pix;
	logic next_pnl_vld;
	logic [23:0] pnl_gfx;
	logic pnl_keyed;
	logic [23:0] pnl_vid;
	logic [23:0] pnl_l2;
	logic [23:0] pnl_l3;
	logic [23:0] pnl_l4;
	logic [23:0] pnl_res;
	logic pnl_in_range;

	always_comb begin
		next_u = u_hold;
		next_v = v_hold;
		next_pnl_pix = pnl_pix;
		next_pnl_vld = 1'b0;
		// scrolling and wrap are address-side; this sees the fetched pixel
		pnl_gfx = gfx_dec(pnl_cfg.gfmt, pnl_in.gfx, lut[pnl_in.gfx[7:0]]);
		pnl_keyed = key_hit(pnl_cfg.gfmt, pnl_in.gfx, pnl_cfg.gkey);
		// 4:2:2 chroma alternates U on even x, V on odd x; the other is held
		if (pnl_cfg.vid_yuv) begin
			pnl_vid = pnl_in.x[0] ? yuv2rgb(pnl_in.vid[7:0], u_hold, pnl_in.vid[15:8])
				: yuv2rgb(pnl_in.vid[7:0], pnl_in.vid[15:8], v_hold);
		end else begin
			pnl_vid = exp565(pnl_in.vid);
		end
		pnl_l2 = layer_en[LAYER_PGFX] ? pnl_gfx : PIX_RESET;
		// with keying on, video only shows through key-matching graphics
		if (layer_en[LAYER_VID] && pnl_in.vid_act && (!pnl_cfg.key_en || pnl_keyed)) begin
			pnl_l2 = pnl_vid;
		end
		pnl_l3 = pnl_l2;
		if (layer_en[LAYER_VALP] && pnl_in.valp_act) begin
			pnl_l3 = ovl(pnl_cfg.vafmt, pnl_in.valp, pnl_cfg.vakey, pnl_cfg.vaplane,
				lut[idx_of(pnl_cfg.vafmt, pnl_in.valp)], pnl_l2);
		end
		pnl_l4 = pnl_l3;
		if (layer_en[LAYER_ALP] && pnl_in.alp_act) begin
			pnl_l4 = ovl(pnl_cfg.afmt, pnl_in.alp, pnl_cfg.akey, ALPHA_OPAQUE,
				lut[idx_of(pnl_cfg.afmt, pnl_in.alp)], pnl_l3);
		end
		pnl_res = pnl_l4;
		if (layer_en[LAYER_PCUR] && cur_hit(pnl_cfg.cur, pnl_in.x, pnl_in.y)) begin
			pnl_res = cur_pix(pnl_cfg.cur, pnl_in.cur, pnl_l4);
		end
		// pixels beyond the largest raster are dropped, not wrapped
		pnl_in_range = pnl_in.x < MAX_W && pnl_in.y < MAX_H;
		if (pnl_en && pnl_in.vld && pnl_in_range) begin
			next_pnl_pix = pnl_res;
			next_pnl_vld = 1'b1;
			if (pnl_in.x[0]) begin
				next_v = pnl_in.vid[15:8];
			end else begin
				next_u = pnl_in.vid[15:8];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pnl_pix <= PIX_RESET;
			pnl_vld <= 1'b0;
			u_hold <= CHROMA_RESET;
			v_hold <= CHROMA_RESET;
		end else begin
			pnl_pix <= next_pnl_pix;
			pnl_vld <= next_pnl_vld;
			u_hold <= next_u;
			v_hold <= next_v;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CRT pipe: graphics and cursor only, no video or alpha planes
	logic [23:0] next_crt_pix;
	logic next_crt_vld;
	logic next_bw_warn;
	logic [23:0] crt_res;

	always_comb begin
		next_crt_pix = crt_pix;
		next_crt_vld = 1'b0;
		crt_res = layer_en[LAYER_SGFX]
			? gfx_dec(crt_cfg.gfmt, crt_in.gfx, lut[crt_in.gfx[7:0]]) : PIX_RESET;
		if (layer_en[LAYER_SCUR] && cur_hit(crt_cfg.cur, crt_in.x, crt_in.y)) begin
			crt_res = cur_pix(crt_cfg.cur, crt_in.cur, crt_res);
		end
		if (crt_en && crt_in.vld && crt_in.x < MAX_W && crt_in.y < MAX_H) begin
			next_crt_pix = crt_res;
			next_crt_vld = 1'b1;
		end
		// advisory only: both pipes fetching with overlay planes on
		next_bw_warn = dual_en && pnl_en && crt_en
			&& (|layer_en[LAYER_ALP:LAYER_VID]);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			crt_pix <= PIX_RESET;
			crt_vld <= 1'b0;
			bw_warn <= 1'b0;
		end else begin
			crt_pix <= next_crt_pix;
			crt_vld <= next_crt_vld;
			bw_warn <= next_bw_warn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	logic crt_go;
	logic crt_cur_on;
	logic pnl_go;
	assign crt_go = crt_en && crt_in.vld && crt_in.x < MAX_W && crt_in.y < MAX_H;
	assign crt_cur_on = layer_en[LAYER_SCUR] && cur_hit(crt_cfg.cur, crt_in.x, crt_in.y);
	assign pnl_go = pnl_en && pnl_in.vld && pnl_in.x < MAX_W && pnl_in.y < MAX_H;

	a_crt_cur_col: assert property (crt_go && crt_cur_on && crt_in.cur == 2'b11
		|=> crt_pix == $past(crt_cfg.cur.col[2])) else $error("crt cursor colour 2 wrong");
	a_crt_cur_clear: assert property (crt_go && crt_cur_on && crt_in.cur == 2'b00
		&& layer_en[LAYER_SGFX] && crt_cfg.gfmt == GF_RGB888
		|=> crt_pix == $past(crt_in.gfx[23:0])) else $error("crt cursor not transparent");
	a_crt_rgb565: assert property (crt_go && !crt_cur_on
		&& layer_en[LAYER_SGFX] && crt_cfg.gfmt == GF_RGB565
		|=> crt_pix[23:19] == $past(crt_in.gfx[15:11]) && crt_pix[15:10] == $past(crt_in.gfx[10:5])
		&& crt_pix[7:3] == $past(crt_in.gfx[4:0])) else $error("565 unpack wrong");
	a_crt_lut_read: assert property (crt_go && !crt_cur_on
		&& layer_en[LAYER_SGFX] && crt_cfg.gfmt == GF_IDX8 && !lut_we
		|=> crt_pix == lut[$past(crt_in.gfx[7:0])]) else $error("lut lookup wrong");
	a_pnl_cur_col: assert property (pnl_go && layer_en[LAYER_PCUR]
		&& cur_hit(pnl_cfg.cur, pnl_in.x, pnl_in.y) && pnl_in.cur == 2'b01
		|=> pnl_pix == $past(pnl_cfg.cur.col[0])) else $error("panel cursor colour 0 wrong");
	a_key_shows_vid: assert property (pnl_go && pnl_cfg.key_en && pnl_keyed
		&& pnl_in.vid_act && layer_en[LAYER_VID] && layer_en[LAYER_PCUR:LAYER_VALP] == 3'h0
		|=> pnl_pix == $past(pnl_vid)) else $error("keyed pixel did not show video");
	a_valp_transp: assert property (pnl_go && layer_en[LAYER_VALP] && pnl_in.valp_act
		&& pnl_cfg.vafmt == AF_RGB565 && pnl_in.valp == pnl_cfg.vakey
		&& layer_en[LAYER_PCUR:LAYER_ALP] == 2'h0
		|=> pnl_pix == $past(pnl_l2)) else $error("video alpha key not transparent");
	a_alpha_opaque: assert property (pnl_go && layer_en[LAYER_ALP] && pnl_in.alp_act
		&& pnl_cfg.afmt == AF_ARGB && pnl_in.alp[15:12] == ALPHA_OPAQUE && !layer_en[LAYER_PCUR]
		|=> pnl_pix == $past(exp4(pnl_in.alp[11:0]))) else $error("opaque alpha not full colour");
	a_pipe_indep: assert property ((pnl_go |=> pnl_vld) and (!pnl_go |=> !pnl_vld)
		and (crt_go |=> crt_vld)) else $error("pipe valid did not follow input");
	a_bw_flag: assert property (dual_en && pnl_en && crt_en && layer_en[LAYER_VID]
		|=> bw_warn) else $error("bandwidth warning missing");

endmodule : cmp_compositor

// >>> rtl/cmp_pkg.sv
// cmp_pkg: shared constants, formats and carrier structs of the layer compositor
package cmp_pkg;

	// layer numbers, bottom to top; the enable vector is indexed by these
	localparam int LAYER_PGFX = 1;
	localparam int LAYER_VID = 2;
	localparam int LAYER_VALP = 3;
	localparam int LAYER_ALP = 4;
	localparam int LAYER_PCUR = 5;
	localparam int LAYER_SGFX = 6;
	localparam int LAYER_SCUR = 7;

	localparam int CW = 11;
	localparam logic [CW-1:0] MAX_W = 11'h780;
	localparam logic [CW-1:0] MAX_H = 11'h5a0;
	localparam logic [CW-1:0] CUR_SIZE = 11'h040;
	localparam logic [1:0] CUR_TRANSP = 2'h0;
	localparam logic [3:0] ALPHA_OPAQUE = 4'hf;
	localparam logic [23:0] PIX_RESET = 24'h000000;
	localparam logic [7:0] CHROMA_RESET = 8'h80;

	// fixed-point colour conversion, scaled by 256
	localparam int YUV_OFS = 128;
	localparam int K_RV = 359;
	localparam int K_GU = 88;
	localparam int K_GV = 183;
	localparam int K_BU = 454;
	// x/15 done as (x*273 + 2048) >> 12
	localparam logic [21:0] DIV15_MUL = 22'h000111;
	localparam logic [21:0] DIV15_RND = 22'h000800;

	typedef enum logic [1:0] {
		GF_IDX8 = 2'b00,
		GF_RGB565 = 2'b01,
		GF_RGB888 = 2'b10
	} cmp_gfmt_t;

	typedef enum logic [1:0] {
		AF_A44 = 2'b00,
		AF_IDX8 = 2'b01,
		AF_ARGB = 2'b10,
		AF_RGB565 = 2'b11
	} cmp_afmt_t;

	typedef struct packed {
		logic [CW-1:0] x;
		logic [CW-1:0] y;
		logic [2:0][23:0] col;
	} cmp_cur_cfg_t;

	typedef struct packed {
		cmp_gfmt_t gfmt;
		logic key_en;
		logic [31:0] gkey;
		logic vid_yuv;
		cmp_afmt_t vafmt;
		logic [15:0] vakey;
		logic [3:0] vaplane;
		cmp_afmt_t afmt;
		logic [15:0] akey;
		cmp_cur_cfg_t cur;
	} cmp_pnl_cfg_t;

	typedef struct packed {
		cmp_gfmt_t gfmt;
		cmp_cur_cfg_t cur;
	} cmp_crt_cfg_t;

	typedef struct packed {
		logic vld;
		logic [CW-1:0] x;
		logic [CW-1:0] y;
		logic [31:0] gfx;
		logic [15:0] vid;
		logic vid_act;
		logic [15:0] valp;
		logic valp_act;
		logic [15:0] alp;
		logic alp_act;
		logic [1:0] cur;
	} cmp_pnl_in_t;

	typedef struct packed {
		logic vld;
		logic [CW-1:0] x;
		logic [CW-1:0] y;
		logic [31:0] gfx;
		logic [1:0] cur;
	} cmp_crt_in_t;

endpackage : cmp_pkg

// >>> tb/cmp_out_sink.sv
// cmp_out_sink: far-side model of one display output path
`timescale 1ns/100ps
module cmp_out_sink (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// pixel stream from the compositor
	input wire logic [23:0] pix,
	input wire logic vld,
	// what the display path has taken
	output logic [15:0] cnt,
	output logic [23:0] last_pix
);
	logic [15:0] next_cnt;
	logic [23:0] next_last;
	// a display path never stalls, so every valid pixel is taken at once
	always_comb begin
		next_cnt = cnt;
		next_last = last_pix;
		if (vld) begin // each pipe feeds only its own path
			next_cnt = cnt + 16'h0001;
			next_last = pix;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt <= 16'h0000;
			last_pix <= 24'h000000;
		end else begin
			cnt <= next_cnt;
			last_pix <= next_last;
		end
	end
endmodule : cmp_out_sink

// >>> tb/tb_top.sv
// tb_top: directed pixel tests of the layer compositor
`timescale 1ns/100ps
module tb_top import cmp_pkg::*; ;
	localparam logic [23:0] BASE = 24'h204060;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:1] layer_en = 7'h00;
	logic pnl_en = 1'b1;
	logic crt_en = 1'b1;
	logic dual_en = 1'b0;
	cmp_pnl_cfg_t pnl_cfg = '0;
	cmp_crt_cfg_t crt_cfg = '0;
	logic lut_we = 1'b0;
	logic [7:0] lut_addr = 8'h00;
	logic [23:0] lut_data = 24'h000000;
	cmp_pnl_in_t pnl_in = '0;
	cmp_crt_in_t crt_in = '0;
	logic [23:0] pnl_pix, crt_pix;
	logic pnl_vld, crt_vld, bw_warn;
	logic [15:0] pnl_cnt, crt_cnt;
	logic [23:0] pnl_last, crt_last;
	int miscompares = 0;
	int total_checks = 0;
	int n_pnl = 0;
	int n_crt = 0;

	always #20 ref_clk = ~ref_clk;

	cmp_compositor DUT (.ref_clk(ref_clk), .srst(srst), .layer_en(layer_en), .pnl_en(pnl_en),
		.crt_en(crt_en), .dual_en(dual_en), .pnl_cfg(pnl_cfg), .crt_cfg(crt_cfg),
		.lut_we(lut_we), .lut_addr(lut_addr), .lut_data(lut_data), .pnl_in(pnl_in),
		.crt_in(crt_in), .pnl_pix(pnl_pix), .pnl_vld(pnl_vld), .crt_pix(crt_pix),
		.crt_vld(crt_vld), .bw_warn(bw_warn));
	cmp_out_sink pnl_sink (.ref_clk(ref_clk), .srst(srst), .pix(pnl_pix), .vld(pnl_vld),
		.cnt(pnl_cnt), .last_pix(pnl_last));
	cmp_out_sink crt_sink (.ref_clk(ref_clk), .srst(srst), .pix(crt_pix), .vld(crt_vld),
		.cnt(crt_cnt), .last_pix(crt_last));

	////////////////////////////////////////////////////////////////////////////////
	task chk_pix(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_pix

	task chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit

	function automatic logic [23:0] e565(input logic [15:0] p);
		return {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
	endfunction : e565

	// per channel (a*top + (15-a)*under)/15, rounded
	function automatic logic [23:0] blend(input int a, input logic [23:0] t, input logic [23:0] u);
		logic [23:0] r;
		int v;
		for (int i = 0; i < 3; i++) begin
			v = ((a * t[i*8+:8] + (15 - a) * u[i*8+:8]) * 273 + 2048) >> 12;
			r[i*8+:8] = v[7:0];
		end
		return r;
	endfunction : blend

	task lut_wr(input logic [7:0] a, input logic [23:0] d);
		@(negedge ref_clk);
		lut_we = 1'b1;
		lut_addr = a;
		lut_data = d;
		@(negedge ref_clk);
		lut_we = 1'b0;
	endtask : lut_wr

	// result is registered: seen at the falling edge after the accepting edge
	task put_pnl(input logic [10:0] x, input logic [10:0] y, input logic [31:0] gfx,
		input logic [1:0] cur, input logic ev, input logic [23:0] exp);
		@(negedge ref_clk);
		pnl_in.vld = 1'b1;
		pnl_in.x = x;
		pnl_in.y = y;
		pnl_in.gfx = gfx;
		pnl_in.cur = cur;
		@(negedge ref_clk);
		pnl_in.vld = 1'b0;
		chk_bit(pnl_vld, ev);
		if (ev) begin
			n_pnl++;
			chk_pix(pnl_pix, exp);
		end
	endtask : put_pnl

	task put_crt(input logic [10:0] x, input logic [10:0] y, input logic [31:0] gfx,
		input logic [1:0] cur, input logic ev, input logic [23:0] exp);
		@(negedge ref_clk);
		crt_in.vld = 1'b1;
		crt_in.x = x;
		crt_in.y = y;
		crt_in.gfx = gfx;
		crt_in.cur = cur;
		@(negedge ref_clk);
		crt_in.vld = 1'b0;
		chk_bit(crt_vld, ev);
		if (ev) begin
			n_crt++;
			chk_pix(crt_pix, exp);
		end
	endtask : put_crt

	task conclude;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge ref_clk);
		srst = 1'b0;
		chk_pix(pnl_pix, PIX_RESET);
		chk_bit(bw_warn, 1'b0);
		lut_wr(8'h5a, 24'h123456);
		layer_en[LAYER_PGFX] = 1'b1;
		put_pnl(11'd0, 11'd0, 32'h0000005a, 2'h0, 1'b1, 24'h123456);
		pnl_cfg.gfmt = GF_RGB565;
		put_pnl(11'd1, 11'd0, 32'h0000f81f, 2'h0, 1'b1, e565(16'hf81f));
		pnl_cfg.gfmt = GF_RGB888;
		put_pnl(11'd2, 11'd0, 32'hab204060, 2'h0, 1'b1, BASE);
		put_pnl(MAX_W, 11'd0, 32'h00204060, 2'h0, 1'b0, BASE);
		put_pnl(MAX_W - 11'd1, MAX_H - 11'd1, 32'h00204060, 2'h0, 1'b1, BASE);
		// colour key on a 16-bit surface, video revealed only on a match
		pnl_cfg.gfmt = GF_RGB565;
		pnl_cfg.key_en = 1'b1;
		pnl_cfg.gkey = 32'h00001234;
		layer_en[LAYER_VID] = 1'b1;
		pnl_in.vid = 16'h07e0;
		pnl_in.vid_act = 1'b1;
		put_pnl(11'd3, 11'd0, 32'hffff1234, 2'h0, 1'b1, e565(16'h07e0));
		put_pnl(11'd4, 11'd0, 32'h00001235, 2'h0, 1'b1, e565(16'h1235));
		pnl_in.vid_act = 1'b0;
		pnl_cfg.key_en = 1'b0;
		pnl_cfg.gfmt = GF_RGB888;
		// alpha layer over graphics
		pnl_cfg.afmt = AF_ARGB;
		layer_en[LAYER_ALP] = 1'b1;
		pnl_in.alp_act = 1'b1;
		pnl_in.alp = 16'h8f0a;
		put_pnl(11'd5, 11'd0, 32'h00204060, 2'h0, 1'b1, blend(8, 24'hff00aa, BASE));
		pnl_in.alp = 16'hf123;
		put_pnl(11'd6, 11'd0, 32'h00204060, 2'h0, 1'b1, 24'h112233);
		pnl_in.alp_act = 1'b0;
		// alpha plane off so the video alpha result reaches the pin untouched
		layer_en[LAYER_ALP] = 1'b0;
		// video alpha in 565 with one planar alpha and a transparency value
		pnl_cfg.vafmt = AF_RGB565;
		pnl_cfg.vakey = 16'hffff;
		pnl_cfg.vaplane = 4'h5;
		layer_en[LAYER_VALP] = 1'b1;
		pnl_in.valp_act = 1'b1;
		pnl_in.valp = 16'h001f;
		put_pnl(11'd7, 11'd0, 32'h00204060, 2'h0, 1'b1, blend(5, e565(16'h001f), BASE));
		pnl_in.valp = 16'hffff;
		put_pnl(11'd8, 11'd0, 32'h00204060, 2'h0, 1'b1, BASE);
		pnl_in.valp_act = 1'b0;
		// panel cursor: every code, then the 64x64 edges
		pnl_cfg.cur.x = 11'd16;
		pnl_cfg.cur.y = 11'd16;
		pnl_cfg.cur.col = {24'h333333, 24'h222222, 24'h111111};
		layer_en[LAYER_PCUR] = 1'b1;
		for (int c = 0; c < 4; c++) begin
			put_pnl(11'd16 + 11'(c), 11'd16, 32'h00204060, 2'(c), 1'b1,
				(c == 0) ? BASE : pnl_cfg.cur.col[c-1]);
		end
		put_pnl(11'd79, 11'd79, 32'h00204060, 2'h3, 1'b1, 24'h333333);
		put_pnl(11'd80, 11'd16, 32'h00204060, 2'h3, 1'b1, BASE);
		put_pnl(11'd15, 11'd16, 32'h00204060, 2'h3, 1'b1, BASE);
		// CRT pipe: its own graphics and cursor only
		layer_en[LAYER_SGFX] = 1'b1;
		crt_cfg.gfmt = GF_RGB565;
		put_crt(11'd0, 11'd0, 32'h0000f800, 2'h0, 1'b1, e565(16'hf800));
		crt_cfg.gfmt = GF_IDX8;
		put_crt(11'd16, 11'd16, 32'h0000005a, 2'h2, 1'b1, 24'h123456);
		crt_cfg.cur.x = 11'd16;
		crt_cfg.cur.y = 11'd16;
		crt_cfg.cur.col = {24'h666666, 24'h555555, 24'h444444};
		layer_en[LAYER_SCUR] = 1'b1;
		put_crt(11'd16, 11'd16, 32'h0000005a, 2'h2, 1'b1, 24'h555555);
		crt_cfg.gfmt = GF_RGB888;
		put_crt(11'd17, 11'd16, 32'hff204060, 2'h0, 1'b1, BASE);
		put_pnl(11'd16, 11'd17, 32'h00204060, 2'h1, 1'b1, 24'h111111);
		crt_en = 1'b0;
		put_crt(11'd1, 11'd1, 32'h0000005a, 2'h0, 1'b0, 24'h0);
		put_pnl(11'd9, 11'd0, 32'h00204060, 2'h0, 1'b1, BASE);
		// yuv 4:2:2: U a0 taken at even x with video off, then V 60 and U 80
		pnl_cfg.vid_yuv = 1'b1;
		pnl_in.vid = 16'ha033;
		put_pnl(11'd10, 11'd0, 32'h00204060, 2'h0, 1'b1, BASE);
		pnl_in.vid_act = 1'b1;
		pnl_in.vid = 16'h6080;
		put_pnl(11'd11, 11'd0, 32'h00204060, 2'h0, 1'b1, 24'h538cb8);
		pnl_in.vid = 16'h8040;
		put_pnl(11'd12, 11'd0, 32'h00204060, 2'h0, 1'b1, 24'h135740);
		pnl_in.vid_act = 1'b0;
		pnl_cfg.vid_yuv = 1'b0;
		crt_en = 1'b1;
		// advisory flag for panel-only planes in dual mode
		dual_en = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk_bit(bw_warn, 1'b1);
		dual_en = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk_bit(bw_warn, 1'b0);
		chk_pix({8'h00, pnl_cnt}, 24'(n_pnl));
		chk_pix({8'h00, crt_cnt}, 24'(n_crt));
		chk_pix(pnl_last, 24'h135740);
		chk_pix(crt_last, BASE);
		conclude();
	end
endmodule : tb_top
